// ### src/rst_ctrl_regs.svh
// Summary of operation
// - The high-bus reset register sits at offset 0x0C and every field reads zero after reset.
// - High-bus bits 0, 5-7, 9, 11, 12, 14 and 16-18 each reset one peripheral unit.
// - High-bus bit 22 resets the debug unit when one, and bits 31 to 23 are reserved.
// - Both registers take word, half-word and byte writes and answer with no wait cycle.
// - Every defined high-bus bit can be written to one and back to zero by software.
// - The low-bus reset register sits at offset 0x10, resets to zero, and maps its bits as listed.
// - Low-bus bit 0 resets general timer 2, and a zero in any bit leaves its peripheral alone.
`ifndef RST_CTRL_REGS_SVH
`define RST_CTRL_REGS_SVH

// ----------------------------------------
// Offsets and reset values
// ----------------------------------------
`define ADDR_HIGH_RST   8'h0C
`define ADDR_LOW_RST    8'h10
`define RESET_VAL       32'h0000_0000
`define MASK_HIGH_RST   32'h0047_5AE1
`define MASK_LOW_RST    32'h7A7E_4933

// ----------------------------------------
// High-bus bit positions
// ----------------------------------------
`define B_SYS_CONFIG_RST    0
`define B_SER6      5
`define B_SER7      6
`define B_SER8      7
`define B_ADC       9
`define B_ADVTMR    11
`define B_SPI_ONE_RST      12
`define B_SER1      14
`define B_TIMER_FIFTEEN_RST     16
`define B_TIMER_SIXTEEN_RST     17
`define B_TIMER_SEVENTEEN_RST     18
`define B_DEBUG     22

// ----------------------------------------
// Low-bus bit positions
// ----------------------------------------
`define B_GP_TIMER_TWO_RST      0
`define B_GP_TIMER_THREE_RST      1
`define B_BASIC_TIMER_SIX_RST      4
`define B_BASIC_TIMER_SEVEN_RST      5
`define B_TIMER_FOURTEEN_RST     8
`define B_WWDG      11
`define B_SPI_TWO_RST      14
`define B_SER2      17
`define B_SER3      18
`define B_SER4      19
`define B_SER5      20
`define B_TW1       21
`define B_TW2       22
`define B_CAN       25
`define B_CLKREC    27
`define B_POWER     28
`define B_DAC       29
`define B_CONSUMER  30

`endif

// ### src/rst_ctrl_pkg.sv
package rst_ctrl_pkg;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic sys_config_rst;
    logic serial6_rst;
    logic serial7_rst;
    logic serial8_rst;
    logic analog_conv_rst;
    logic adv_timer_one_rst;
    logic spi_one_rst;
    logic serial1_rst;
    logic timer_fifteen_rst;
    logic timer_sixteen_rst;
    logic timer_seventeen_rst;
    logic debug_unit_rst;
  } high_rst_t;

  typedef struct packed {
    logic gp_timer_two_rst;
    logic gp_timer_three_rst;
    logic basic_timer_six_rst;
    logic basic_timer_seven_rst;
    logic timer_fourteen_rst;
    logic window_watchdog_rst;
    logic spi_two_rst;
    logic serial2_rst;
    logic serial3_rst;
    logic serial4_rst;
    logic serial5_rst;
    logic two_wire_one_rst;
    logic two_wire_two_rst;
    logic can_bus_rst;
    logic clock_recovery_rst;
    logic power_iface_rst;
    logic analog_out_rst;
    logic consumer_control_rst;
  } low_rst_t;

endpackage

// ### src/masked_reset_reg.sv
`timescale 1ns/1ps
module masked_reset_reg #(
  parameter logic [31:0] MASK = 32'hFFFF_FFFF
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [3:0]  be,
  input  wire logic [31:0] wdata,
  // Stored value
  output logic      [31:0] q
);

  // ----------------------------------------
  // Byte lanes
  // ----------------------------------------
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          q[lane*8 +: 8] <= 8'h00;
        end else if (wr_en && be[lane]) begin
          q[lane*8 +: 8] <= wdata[lane*8 +: 8] & MASK[lane*8 +: 8];
        end
      end
    end
  endgenerate

endmodule

// ### src/peripheral_reset_registers.sv
`timescale 1ns/1ps
`include "rst_ctrl_regs.svh"
module peripheral_reset_registers
  import rst_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Processor bus
  input  wire bus_req_t    bus_req,
  output logic      [31:0] bus_rdata,
  output logic             bus_ready,
  // Peripheral resets
  output high_rst_t        high_rst,
  output low_rst_t         low_rst
);

  logic        rst_meta_reg;
  logic        rst_sync_n;
  logic [31:0] high_q;
  logic [31:0] low_q;
  logic [31:0] rdata_reg;
  logic        hit_high;
  logic        hit_low;
  logic        wr_high;
  logic        wr_low;
  logic        rd_en;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  assign hit_high  = ({bus_req.addr[7:2], 2'b00} == `ADDR_HIGH_RST);
  assign hit_low   = ({bus_req.addr[7:2], 2'b00} == `ADDR_LOW_RST);
  assign wr_high   = bus_req.sel && bus_req.write && hit_high;
  assign wr_low    = bus_req.sel && bus_req.write && hit_low;
  assign rd_en     = bus_req.sel && !bus_req.write;
  assign bus_ready = 1'b1;

  // ----------------------------------------
  // Reset registers
  // ----------------------------------------
  masked_reset_reg #(.MASK(`MASK_HIGH_RST)) u_high_reg (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .wr_en (wr_high),
    .be    (bus_req.be),
    .wdata (bus_req.wdata),
    .q     (high_q)
  );

  masked_reset_reg #(.MASK(`MASK_LOW_RST)) u_low_reg (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .wr_en (wr_low),
    .be    (bus_req.be),
    .wdata (bus_req.wdata),
    .q     (low_q)
  );

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata_reg <= `RESET_VAL;
    end else if (rd_en) begin
      if (hit_high) begin
        rdata_reg <= high_q;
      end else if (hit_low) begin
        rdata_reg <= low_q;
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end
  end
  assign bus_rdata = rdata_reg;

  // ----------------------------------------
  // Reset outputs
  // ----------------------------------------
  always_comb begin
    high_rst.sys_config_rst      = high_q[`B_SYS_CONFIG_RST];
    high_rst.serial6_rst         = high_q[`B_SER6];
    high_rst.serial7_rst         = high_q[`B_SER7];
    high_rst.serial8_rst         = high_q[`B_SER8];
    high_rst.analog_conv_rst     = high_q[`B_ADC];
    high_rst.adv_timer_one_rst   = high_q[`B_ADVTMR];
    high_rst.spi_one_rst         = high_q[`B_SPI_ONE_RST];
    high_rst.serial1_rst         = high_q[`B_SER1];
    high_rst.timer_fifteen_rst   = high_q[`B_TIMER_FIFTEEN_RST];
    high_rst.timer_sixteen_rst   = high_q[`B_TIMER_SIXTEEN_RST];
    high_rst.timer_seventeen_rst = high_q[`B_TIMER_SEVENTEEN_RST];
    high_rst.debug_unit_rst      = high_q[`B_DEBUG];
  end

  always_comb begin
    low_rst.gp_timer_two_rst      = low_q[`B_GP_TIMER_TWO_RST];
    low_rst.gp_timer_three_rst    = low_q[`B_GP_TIMER_THREE_RST];
    low_rst.basic_timer_six_rst   = low_q[`B_BASIC_TIMER_SIX_RST];
    low_rst.basic_timer_seven_rst = low_q[`B_BASIC_TIMER_SEVEN_RST];
    low_rst.timer_fourteen_rst    = low_q[`B_TIMER_FOURTEEN_RST];
    low_rst.window_watchdog_rst   = low_q[`B_WWDG];
    low_rst.spi_two_rst           = low_q[`B_SPI_TWO_RST];
    low_rst.serial2_rst           = low_q[`B_SER2];
    low_rst.serial3_rst           = low_q[`B_SER3];
    low_rst.serial4_rst           = low_q[`B_SER4];
    low_rst.serial5_rst           = low_q[`B_SER5];
    low_rst.two_wire_one_rst      = low_q[`B_TW1];
    low_rst.two_wire_two_rst      = low_q[`B_TW2];
    low_rst.can_bus_rst           = low_q[`B_CAN];
    low_rst.clock_recovery_rst    = low_q[`B_CLKREC];
    low_rst.power_iface_rst       = low_q[`B_POWER];
    low_rst.analog_out_rst        = low_q[`B_DAC];
    low_rst.consumer_control_rst  = low_q[`B_CONSUMER];
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence seq_full_write_high;
    bus_req.sel && bus_req.write && hit_high && (bus_req.be == 4'hF);
  endsequence

  sequence seq_full_write_low;
    bus_req.sel && bus_req.write && hit_low && (bus_req.be == 4'hF);
  endsequence

  sequence seq_read_high;
    bus_req.sel && !bus_req.write && hit_high;
  endsequence

  AST_HIGH_RESET_ZERO: assert property (
    @(posedge clk) $rose(rst_sync_n) |-> (high_q == `RESET_VAL) && (low_q == `RESET_VAL))
    else $error("Reset registers not zero after reset");

  AST_HIGH_CONFIG_OUT: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    seq_full_write_high |=> high_rst.sys_config_rst == $past(bus_req.wdata[0]))
    else $error("Config reset does not follow written bit");

  AST_DEBUG_OUT: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    seq_full_write_high |=> (high_rst.debug_unit_rst == $past(bus_req.wdata[22]))
      && (high_q[31:23] == 9'h000))
    else $error("Debug reset or reserved high bits wrong");

  AST_BYTE_LANE: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    (wr_high && (bus_req.be == 4'h1)) |=> $stable(high_q[31:8]))
    else $error("Byte write disturbed other lanes");

  AST_READY_ALWAYS: assert property (
    @(posedge clk) disable iff (!rst_sync_n) bus_req.sel |-> bus_ready)
    else $error("Wait cycle inserted");

  AST_HIGH_WRITE_LOAD: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    seq_full_write_high ##1 seq_read_high |=> bus_rdata == ($past(bus_req.wdata, 2) & `MASK_HIGH_RST))
    else $error("High register write did not read back");

  AST_LOW_WRITE_LOAD: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    seq_full_write_low |=> low_q == ($past(bus_req.wdata) & `MASK_LOW_RST))
    else $error("Low register write wrong");

  AST_TIMER2_HOLD: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    !wr_low |=> $stable(low_rst.gp_timer_two_rst) && $stable(low_q))
    else $error("Low register changed without a write");

  AST_RESERVED_ZERO: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    ((high_q & ~`MASK_HIGH_RST) == 32'h0000_0000) && ((low_q & ~`MASK_LOW_RST) == 32'h0000_0000))
    else $error("Reserved bit set");

  sequence seq_read_low;
    bus_req.sel && !bus_req.write && hit_low;
  endsequence

  sequence seq_read_other;
    bus_req.sel && !bus_req.write && !hit_high && !hit_low;
  endsequence

  AST_LOW_READ_BACK: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    seq_read_low |=> bus_rdata == $past(low_q))
    else $error("Low register read data wrong");

  AST_OTHER_READ_ZERO: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    seq_read_other |=> bus_rdata == 32'h0000_0000)
    else $error("Unmapped read not zero");

  AST_RDATA_HOLD: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    !rd_en |=> $stable(bus_rdata))
    else $error("Read data changed without a read");

  AST_TIMER2_SET: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    (wr_low && bus_req.be[0] && bus_req.wdata[`B_GP_TIMER_TWO_RST]) |=> low_rst.gp_timer_two_rst)
    else $error("General timer 2 reset not asserted");

  AST_HALF_WRITE_LOW: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    (wr_low && (bus_req.be == 4'h3)) |=> $stable(low_q[31:16]))
    else $error("Half-word write disturbed upper lanes");

  AST_RESET_LEVEL: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    (high_q[`B_DEBUG] && !wr_high) |=> high_rst.debug_unit_rst)
    else $error("Debug reset dropped while its bit holds one");

endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import rst_ctrl_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  bus_req_t    bus_req  = '0;
  logic [31:0] bus_rdata;
  logic        bus_ready;
  high_rst_t   high_rst;
  low_rst_t    low_rst;
  int          n_fail   = 0;
  int          n_checks = 0;
  int          cycles   = 0;
  logic [31:0] exp_h    = '0;
  logic [31:0] exp_l    = '0;
  logic [31:0] mask_h   = '0;
  logic [31:0] mask_l   = '0;
  int          hb[12]   = '{0, 5, 6, 7, 9, 11, 12, 14, 16, 17, 18, 22};
  int          lb[18]   = '{0, 1, 4, 5, 8, 11, 14, 17, 18, 19, 20, 21, 22, 25, 27, 28, 29, 30};

  peripheral_reset_registers i_dut (
    .clk       (clk),
    .rst_n     (rst_n),
    .bus_req   (bus_req),
    .bus_rdata (bus_rdata),
    .bus_ready (bus_ready),
    .high_rst  (high_rst),
    .low_rst   (low_rst)
  );

  // ----------------------------------------
  // Clock and timeout
  // ----------------------------------------
  always #20 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      $display("[FAIL] t=%0t timeout got=%h exp=%h", $time, cycles, 0);
      n_fail = n_fail + 1;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [11:0] pack_h(input logic [31:0] v);
    logic [11:0] r;
    for (int i = 0; i < 12; i++) r[11-i] = v[hb[i]];
    return r;
  endfunction

  function automatic logic [17:0] pack_l(input logic [31:0] v);
    logic [17:0] r;
    for (int i = 0; i < 18; i++) r[17-i] = v[lb[i]];
    return r;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic outs();
    chk(32'(high_rst), 32'(pack_h(exp_h)));
    chk(32'(low_rst), 32'(pack_l(exp_l)));
    chk(32'(bus_ready), 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] bm, input logic [31:0] d);
    logic [31:0] lm;
    lm = {{8{bm[3]}}, {8{bm[2]}}, {8{bm[1]}}, {8{bm[0]}}};
    @(posedge clk);
    bus_req <= '{sel: 1'b1, write: 1'b1, addr: a, be: bm, wdata: d};
    @(posedge clk);
    bus_req.sel <= 1'b0;
    if (a[7:2] == 6'h03) exp_h = (exp_h & ~lm) | (d & lm & mask_h);
    if (a[7:2] == 6'h04) exp_l = (exp_l & ~lm) | (d & lm & mask_l);
    #1;
    outs();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    bus_req <= '{sel: 1'b1, write: 1'b0, addr: a, be: 4'hF, wdata: 32'h0};
    @(posedge clk);
    bus_req.sel <= 1'b0;
    #1;
    chk(bus_rdata, e);
    chk(32'(bus_ready), 32'h1);
  endtask

  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge clk);
    bus_req <= '{sel: 1'b1, write: 1'b1, addr: a, be: 4'hF, wdata: d};
    @(posedge clk);
    bus_req <= '{sel: 1'b1, write: 1'b0, addr: a, be: 4'hF, wdata: 32'h0};
    @(posedge clk);
    bus_req.sel <= 1'b0;
    if (a[7:2] == 6'h03) exp_h = d & mask_h;
    if (a[7:2] == 6'h04) exp_l = d & mask_l;
    #1;
    chk(bus_rdata, e);
    outs();
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    exp_h = '0;
    exp_l = '0;
    repeat (16) @(posedge clk);
    #1;
    outs();
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 12; i++) mask_h[hb[i]] = 1'b1;
    for (int i = 0; i < 18; i++) mask_l[lb[i]] = 1'b1;
    do_reset();
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h0);
    $display("test reset_values done");
    wr(8'h0C, 4'hF, 32'hFFFF_FFFF);
    wr(8'h10, 4'hF, 32'hFFFF_FFFF);
    rd(8'h0C, mask_h);
    rd(8'h10, mask_l);
    wr_rd(8'h0C, 32'hA5A5_5A5A, 32'hA5A5_5A5A & mask_h);
    wr_rd(8'h10, 32'h5A5A_A5A5, 32'h5A5A_A5A5 & mask_l);
    $display("test all_ones done");
    for (int i = 0; i < 12; i++) begin
      wr(8'h0C, 4'hF, 32'(1) << hb[i]);
      rd(8'h0C, 32'(1) << hb[i]);
    end
    for (int i = 0; i < 18; i++) begin
      wr(8'h10, 4'hF, 32'(1) << lb[i]);
      rd(8'h10, 32'(1) << lb[i]);
    end
    wr(8'h0C, 4'hF, 32'h0);
    wr(8'h10, 4'hF, 32'h0);
    rd(8'h0C, 32'h0);
    $display("test walking_one done");
    for (int n = 0; n < 4; n++) begin
      wr(8'h0C, 4'(1 << n), 32'hFFFF_FFFF);
      rd(8'h0C, exp_h);
    end
    wr(8'h0C, 4'h2, 32'h0);
    wr(8'h10, 4'h3, 32'hFFFF_FFFF);
    rd(8'h10, mask_l & 32'h0000_FFFF);
    wr(8'h10, 4'hC, 32'hFFFF_FFFF);
    wr(8'h10, 4'h8, 32'h0);
    rd(8'h10, exp_l);
    rd(8'h0C, exp_h);
    $display("test lanes done");
    wr(8'h14, 4'hF, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h10, exp_l);
    $display("test other_addr done");
    do_reset();
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h0);
    $display("test second_reset done");
    give_verdict();
  end
endmodule
